// ===== hw/adcrm_host.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "adcrm_consts.svh"

// Overview of operation
// RULE1: gain low byte in upper half
// RULE2: read-only map checksum at 3Eh
// RULE3: host writes only zero to 3Fh
// RULE4: device output released while deselected
// RULE5: never two chip selects together
// RULE6: address one device at a time
// RULE7: common clock, simultaneous sync strobe
// RULE8: host tracks zero-phase reference channel; this host does not track one and leaves the reference device to software
// RULE9: track conversions via ready or sync
// RULE10: clock counting alone cannot recover
// RULE11: permanent select needs both CRCs
// RULE12: word size defaults to 24 bits
// RULE13: checksum follows register changes
module adcrm_host
   import adcrm_pkg::*;
#(
   parameter int CONV_HALF = `ADCRM_CONV_HALF,
   parameter int SCLK_HALF = `ADCRM_SCLK_HALF,
   parameter int SYNC_LOW = `ADCRM_SYNC_LOW
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   adcrm_link_if.host ifc
);

   adcrm_host_t r_reg, r_next;
   logic acc;
   logic take;
   logic done_set;
   logic done_clr;
   logic [15:0] wd_eff;

   function automatic logic reg_hit(input logic [7:0] a);
      case (a)
         `ADCRM_OFS_CTRL, `ADCRM_OFS_ADDR, `ADCRM_OFS_WDATA,
         `ADCRM_OFS_RDATA, `ADCRM_OFS_STATUS: reg_hit = 1'b1;
         default: reg_hit = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] reg_rd(input adcrm_host_t s,
                                          input logic [7:0] a);
      reg_rd = 32'h0000_0000;
      case (a)
         `ADCRM_OFS_CTRL: begin
            reg_rd[`ADCRM_CTRL_READ] = s.rd;
            reg_rd[`ADCRM_CTRL_SEL_LO +: 2] = s.sel;
         end
         `ADCRM_OFS_ADDR: reg_rd[5:0] = s.addr;
         `ADCRM_OFS_WDATA: reg_rd[15:0] = s.wdata;
         `ADCRM_OFS_RDATA: reg_rd[15:0] = s.rdata;
         `ADCRM_OFS_STATUS: begin
            reg_rd[`ADCRM_STAT_BUSY] = (s.st != HS_IDLE);
            reg_rd[`ADCRM_STAT_DONE] = s.done;
            reg_rd[`ADCRM_STAT_CNT_LO +: 8] = s.rcnt;
         end
         default: reg_rd = 32'h0000_0000;
      endcase
   endfunction

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      r_next = r_reg;
      done_set = 1'b0;
      done_clr = 1'b0;
      wd_eff = r_reg.wdata;

      // apb: one wait cycle, write lands on the ready edge
      acc = psel & penable;
      take = acc & r_reg.pready;
      r_next.pready = acc & ~r_reg.pready;
      r_next.pslverr = acc & ~r_reg.pready & ~reg_hit(paddr);
      if (acc & ~r_reg.pready) begin
         r_next.prdata = reg_hit(paddr) ? reg_rd(r_reg, paddr)
                                        : 32'h0000_0000;
      end

      // conversion clock divider
      if (r_reg.convc == 8'(CONV_HALF - 1)) begin
         r_next.convc = 8'h00;
         r_next.conv = ~r_reg.conv;
      end else begin
         r_next.convc = r_reg.convc + 8'h01;
      end

      // pin inputs through two stages
      r_next.miso_m = ifc.miso_line;
      r_next.miso_q = r_reg.miso_m;
      r_next.rdy_m = ifc.sample_ready_n;
      r_next.rdy_q = r_reg.rdy_m;
      r_next.rdy_d = r_reg.rdy_q;
      // RULE10: no bare clock counting
      // RULE9: count ready pulses
      if (~r_reg.rdy_q & r_reg.rdy_d) begin
         r_next.rcnt = r_reg.rcnt + 8'h01;
      end

      // sync strobe timer
      if (r_reg.synccnt != 8'h00) begin
         r_next.synccnt = r_reg.synccnt - 8'h01;
         r_next.sync_n = (r_reg.synccnt == 8'h01);
      end

      if (take && pwrite) begin
         case (paddr)
            `ADCRM_OFS_ADDR: r_next.addr = pwdata[5:0];
            `ADCRM_OFS_WDATA: r_next.wdata = pwdata[15:0];
            `ADCRM_OFS_STATUS: done_clr = pwdata[`ADCRM_STAT_DONE];
            `ADCRM_OFS_CTRL: begin
               // RULE7: one strobe, all devices
               if (pwdata[`ADCRM_CTRL_SYNC]) begin
                  r_next.synccnt = 8'(SYNC_LOW);
                  r_next.sync_n = 1'b0;
               end
               // RULE8: reference device kept by software
               if (r_reg.st == HS_IDLE) begin
                  r_next.rd = pwdata[`ADCRM_CTRL_READ];
                  r_next.sel = pwdata[`ADCRM_CTRL_SEL_LO +: 2];
               end
            end
            default: r_next.addr = r_reg.addr;
         endcase
      end

      // RULE3: reserved word written as zero
      if (r_reg.addr == `ADCRM_ADDR_RSVD_TAIL) begin
         wd_eff = `ADCRM_RSVD_RST;
      end

      case (r_reg.st)
         HS_IDLE: begin
            if (take && pwrite && paddr == `ADCRM_OFS_CTRL &&
                pwdata[`ADCRM_CTRL_START]) begin
               r_next.st = HS_XFER;
               // RULE12: two 24-bit words per frame
               r_next.tx = {pwdata[`ADCRM_CTRL_READ], 1'b0, r_reg.addr,
                            wd_eff, 24'h000000};
               r_next.mosi = pwdata[`ADCRM_CTRL_READ];
               // RULE5: exactly one select low
               // RULE6: only the addressed device
               r_next.cs_n = ~(4'h1 << pwdata[`ADCRM_CTRL_SEL_LO +: 2]);
               r_next.sclk = 1'b0;
               r_next.hcnt = 8'h00;
               r_next.bitn = 6'h00;
            end
         end
         HS_XFER: begin
            if (r_reg.hcnt == 8'(SCLK_HALF - 1)) begin
               r_next.hcnt = 8'h00;
               if (!r_reg.sclk) begin
                  r_next.sclk = 1'b1;
                  r_next.rx = {r_reg.rx[46:0], r_reg.miso_q};
               end else begin
                  r_next.sclk = 1'b0;
                  r_next.tx = {r_reg.tx[46:0], 1'b0};
                  r_next.mosi = r_reg.tx[46];
                  r_next.bitn = r_reg.bitn + 6'h01;
                  if (r_reg.bitn == 6'(`ADCRM_FRAME_BITS - 1)) begin
                     r_next.st = HS_FIN;
                     r_next.mosi = 1'b0;
                  end
               end
            end else begin
               r_next.hcnt = r_reg.hcnt + 8'h01;
            end
         end
         HS_FIN: begin
            if (r_reg.hcnt == 8'(SCLK_HALF - 1)) begin
               r_next.hcnt = 8'h00;
               // RULE11: select released after every frame
               r_next.cs_n = 4'hf;
               r_next.st = HS_IDLE;
               done_set = 1'b1;
               if (r_reg.rd) begin
                  // RULE1: upper 16 bits of answer word
                  r_next.rdata = r_reg.rx[23:8];
               end
            end else begin
               r_next.hcnt = r_reg.hcnt + 8'h01;
            end
         end
         default: begin
            r_next.st = HS_IDLE;
            r_next.cs_n = 4'hf;
         end
      endcase

      // set wins over clear
      r_next.done = (r_reg.done & ~done_clr) | done_set;
   end

   // ***********************************************
   // state register
   // ***********************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.st <= HS_IDLE;
         r_reg.cs_n <= 4'hf;
         r_reg.sync_n <= 1'b1;
         r_reg.rdy_m <= 1'b1;
         r_reg.rdy_q <= 1'b1;
         r_reg.rdy_d <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   // RULE7: same clock to every device
   assign ifc.conversion_clock_in = r_reg.conv;
   assign ifc.sclk = r_reg.sclk;
   assign ifc.cs_n = r_reg.cs_n;
   assign ifc.mosi = r_reg.mosi;
   assign ifc.sync_n = r_reg.sync_n;

endmodule

// ===== hw/adcrm_consts.svh
`ifndef ADCRM_CONSTS_SVH
`define ADCRM_CONSTS_SVH

// ***********************************************
// device register map
// ***********************************************
`define ADCRM_ADDR_GAIN7_LO 6'h30
`define ADCRM_ADDR_MAP_CRC 6'h3e
`define ADCRM_ADDR_RSVD_TAIL 6'h3f
`define ADCRM_GAIN7_LO_RST 8'h00
`define ADCRM_CRC_RST 16'h0000
`define ADCRM_RSVD_RST 16'h0000
`define ADCRM_CRC_POLY 16'h1021

// ***********************************************
// link framing
// ***********************************************
`define ADCRM_WORD_BITS 24
`define ADCRM_FRAME_BITS 48
`define ADCRM_CMD_RD 23
`define ADCRM_CMD_ADDR_HI 21
`define ADCRM_CMD_ADDR_LO 16
`define ADCRM_NDEV 4

// ***********************************************
// controller registers (byte offsets)
// ***********************************************
`define ADCRM_OFS_CTRL 8'h00
`define ADCRM_OFS_ADDR 8'h04
`define ADCRM_OFS_WDATA 8'h08
`define ADCRM_OFS_RDATA 8'h0c
`define ADCRM_OFS_STATUS 8'h10
`define ADCRM_CTRL_START 0
`define ADCRM_CTRL_READ 1
`define ADCRM_CTRL_SYNC 2
`define ADCRM_CTRL_SEL_LO 4
`define ADCRM_STAT_BUSY 0
`define ADCRM_STAT_DONE 1
`define ADCRM_STAT_CNT_LO 8

// ***********************************************
// timing
// ***********************************************
`define ADCRM_PCLK_NS 25
`define ADCRM_CONV_PERIOD_NS 100
`define ADCRM_CONV_HALF ((`ADCRM_CONV_PERIOD_NS/2)/`ADCRM_PCLK_NS)
`define ADCRM_SCLK_PERIOD_NS 1600
`define ADCRM_SCLK_HALF ((`ADCRM_SCLK_PERIOD_NS/2)/`ADCRM_PCLK_NS)
`define ADCRM_SYNC_LOW_NS 400
`define ADCRM_SYNC_LOW \
   ((`ADCRM_SYNC_LOW_NS+`ADCRM_PCLK_NS-1)/`ADCRM_PCLK_NS)
`define ADCRM_SAMPLE_CYCLES 64

`endif

// ===== hw/adcrm_pkg.sv
package adcrm_pkg;

   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_XFER = 3'b010,
      HS_FIN  = 3'b100
   } adcrm_hstate_t;

   typedef struct packed {
      logic sclk_m, sclk_q, sclk_d;
      logic cs_m, cs_q;
      logic mosi_m, mosi_q;
      logic sync_m, sync_q, sync_d;
      logic [5:0] bitcnt;
      logic [23:0] rx;
      logic [23:0] tx;
      logic miso;
      logic oe;
      logic [7:0] gain;
      logic [15:0] rsvd;
      logic [15:0] crc;
      logic [15:0] per;
      logic rdy_n;
   } adcrm_dev_t;

   typedef struct packed {
      adcrm_hstate_t st;
      logic [7:0] hcnt;
      logic sclk;
      logic [5:0] bitn;
      logic [47:0] tx;
      logic [47:0] rx;
      logic mosi;
      logic [3:0] cs_n;
      logic [7:0] convc;
      logic conv;
      logic [7:0] synccnt;
      logic sync_n;
      logic miso_m, miso_q;
      logic rdy_m, rdy_q, rdy_d;
      logic [7:0] rcnt;
      logic rd;
      logic [1:0] sel;
      logic [5:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic done;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } adcrm_host_t;

endpackage

// ===== hw/adcrm_link_if.sv
`timescale 1ns/1ps
interface adcrm_link_if;
   logic conversion_clock_in;
   logic sclk;
   logic [3:0] cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic sync_n;
   logic sample_ready_n;
   wire miso_line;

   // released line settles to its pull-down level
   assign miso_line = miso_oe ? miso : 1'b0;

   modport host (
      output conversion_clock_in, sclk, cs_n, mosi, sync_n,
      input miso_line, sample_ready_n
   );
   modport dev (
      input conversion_clock_in, sclk, cs_n, mosi, sync_n,
      output miso, miso_oe, sample_ready_n
   );
endinterface

// ===== hw/adcrm_device.sv
`timescale 1ns/1ps
`include "adcrm_consts.svh"

module adcrm_device
   import adcrm_pkg::*;
#(
   parameter int DEV_IDX = 0,
   parameter int SAMPLE_CYCLES = `ADCRM_SAMPLE_CYCLES
) (
   // reset
   input wire logic presetn,
   // link
   adcrm_link_if.dev ifc,
   // user side
   output logic [7:0] ch7_gain_factor_low,
   output logic [15:0] map_checksum
);

   adcrm_dev_t r_reg, r_next;
   logic rise, fall;
   logic [23:0] cmd;

   function automatic logic [15:0] map_crc(input logic [23:0] d);
      logic [15:0] c;
      c = `ADCRM_CRC_RST;
      for (int i = 23; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `ADCRM_CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

   function automatic logic [15:0] reg_read(input adcrm_dev_t s,
                                            input logic [5:0] a);
      case (a)
         `ADCRM_ADDR_GAIN7_LO: reg_read = {s.gain, 8'h00};
         `ADCRM_ADDR_MAP_CRC: reg_read = s.crc;
         `ADCRM_ADDR_RSVD_TAIL: reg_read = s.rsvd;
         default: reg_read = 16'h0000;
      endcase
   endfunction

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      r_next = r_reg;
      r_next.sclk_m = ifc.sclk;
      r_next.sclk_q = r_reg.sclk_m;
      r_next.sclk_d = r_reg.sclk_q;
      r_next.cs_m = ifc.cs_n[DEV_IDX];
      r_next.cs_q = r_reg.cs_m;
      r_next.mosi_m = ifc.mosi;
      r_next.mosi_q = r_reg.mosi_m;
      r_next.sync_m = ifc.sync_n;
      r_next.sync_q = r_reg.sync_m;
      r_next.sync_d = r_reg.sync_q;
      rise = r_reg.sclk_q & ~r_reg.sclk_d;
      fall = ~r_reg.sclk_q & r_reg.sclk_d;
      cmd = {r_reg.rx[22:0], r_reg.mosi_q};
      // RULE4: release line when deselected
      r_next.oe = ~r_reg.cs_q;
      if (r_reg.cs_q) begin
         r_next.bitcnt = 6'h00;
         r_next.miso = 1'b0;
      end else if (rise) begin
         r_next.rx = cmd;
         r_next.bitcnt = r_reg.bitcnt + 6'h01;
         // RULE12: 24-bit command word
         if (r_reg.bitcnt == 6'(`ADCRM_WORD_BITS - 1)) begin
            r_next.tx = {reg_read(r_reg,
               cmd[`ADCRM_CMD_ADDR_HI:`ADCRM_CMD_ADDR_LO]), 8'h00};
            if (!cmd[`ADCRM_CMD_RD]) begin
               case (cmd[`ADCRM_CMD_ADDR_HI:`ADCRM_CMD_ADDR_LO])
                  // RULE1: upper byte holds gain
                  `ADCRM_ADDR_GAIN7_LO: r_next.gain = cmd[15:8];
                  `ADCRM_ADDR_RSVD_TAIL: r_next.rsvd = cmd[15:0];
                  default: r_next.rsvd = r_reg.rsvd;
               endcase
            end
         end
      end else if (fall && r_reg.bitcnt >= 6'(`ADCRM_WORD_BITS)) begin
         r_next.miso = r_reg.tx[23];
         r_next.tx = {r_reg.tx[22:0], 1'b0};
      end
      // RULE2: checksum over the map
      // RULE13: refreshed every cycle
      r_next.crc = map_crc({r_reg.gain, r_reg.rsvd});
      // RULE7: realign period on sync
      if (~r_reg.sync_q & r_reg.sync_d) begin
         r_next.per = 16'h0000;
         r_next.rdy_n = 1'b1;
      end else if (r_reg.per == 16'(SAMPLE_CYCLES - 1)) begin
         r_next.per = 16'h0000;
         r_next.rdy_n = 1'b0;
      end else begin
         r_next.per = r_reg.per + 16'h0001;
         r_next.rdy_n = 1'b1;
      end
   end

   // ***********************************************
   // state register
   // ***********************************************
   always_ff @(posedge ifc.conversion_clock_in or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.cs_m <= 1'b1;
         r_reg.cs_q <= 1'b1;
         r_reg.sync_m <= 1'b1;
         r_reg.sync_q <= 1'b1;
         r_reg.sync_d <= 1'b1;
         r_reg.rdy_n <= 1'b1;
         r_reg.gain <= `ADCRM_GAIN7_LO_RST;
         r_reg.rsvd <= `ADCRM_RSVD_RST;
         r_reg.crc <= `ADCRM_CRC_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign ifc.miso = r_reg.miso;
   assign ifc.miso_oe = r_reg.oe;
   assign ifc.sample_ready_n = r_reg.rdy_n;
   assign ch7_gain_factor_low = r_reg.gain;
   assign map_checksum = r_reg.crc;

endmodule

// ===== verification/adcrm_link_checker.sv
`timescale 1ns/1ps
module adcrm_link_checker #(
   parameter int SC = 8
) (
   // clocks and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conversion_clock_in,
   // link signals
   input wire logic sclk,
   input wire logic [3:0] cs_n,
   input wire logic miso_oe,
   input wire logic sync_n,
   input wire logic sample_ready_n
);
   localparam int SC_HI = SC + 6;
   logic sclk_q;
   logic [6:0] nbit;

   // ***********************************************
   // sclk rising edges within a frame
   // ***********************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         nbit <= 7'h00;
      end else begin
         sclk_q <= sclk;
         if (&cs_n) begin
            nbit <= 7'h00;
         end else if (sclk && !sclk_q) begin
            nbit <= nbit + 7'h01;
         end
      end
   end

   a_cs_onehot: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0(~cs_n)) else $error("two chip selects low");
   a_cs_held: assert property (@(posedge pclk) disable iff (!presetn)
      sclk |-> $stable(cs_n)) else $error("select moved mid frame");
   a_sclk_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (&cs_n) |-> !sclk) else $error("sclk active while idle");
   a_frame_len: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(&cs_n) |-> nbit == 7'd48) else $error("frame not two words");
   a_sync_width: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(sync_n) |=> !sync_n [*8] ##1 !sync_n [*7] ##1 sync_n)
      else $error("sync strobe width wrong");
   a_conv_period: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(conversion_clock_in) |=> conversion_clock_in ##1
      !conversion_clock_in ##1 !conversion_clock_in ##1 conversion_clock_in)
      else $error("conversion clock period wrong");
   a_miso_release: assert property (@(posedge conversion_clock_in)
      disable iff (!presetn) $rose(&cs_n) |-> ##[1:5] !miso_oe)
      else $error("output not released");
   a_miso_quiet: assert property (@(posedge conversion_clock_in)
      disable iff (!presetn) cs_n[0] [*4] |-> !miso_oe)
      else $error("output driven while deselected");
   a_ready_period: assert property (@(posedge conversion_clock_in)
      disable iff (!presetn || !sync_n)
      $fell(sample_ready_n) |=> sample_ready_n [*7] ##1 !sample_ready_n)
      else $error("ready period wrong");
   a_sync_align: assert property (@(posedge conversion_clock_in)
      disable iff (!presetn) $fell(sync_n) |-> ##[SC:SC_HI] !sample_ready_n)
      else $error("no ready after sync");
endmodule

// ===== verification/tb_adc_regmap_tail_and_bus_sharing.sv
`timescale 1ns/1ps
`include "adcrm_consts.svh"
module tb_adc_regmap_tail_and_bus_sharing;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] gain_o;
   logic [15:0] crc_o;
   logic [7:0] gain_m = 8'h00;
   logic [31:0] q;
   logic e;
   logic [15:0] d;
   logic [7:0] c0;
   int fails = 0;
   int n_tests = 0;

   adcrm_link_if adcrm_link_if_i();
   adcrm_host adcrm_host_i(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ifc(adcrm_link_if_i.host));
   adcrm_device #(.DEV_IDX(0), .SAMPLE_CYCLES(8)) adcrm_device_i(
      .presetn(presetn), .ifc(adcrm_link_if_i.dev),
      .ch7_gain_factor_low(gain_o), .map_checksum(crc_o));
   adcrm_link_checker #(.SC(8)) adcrm_link_checker_i(.pclk(pclk),
      .presetn(presetn),
      .conversion_clock_in(adcrm_link_if_i.conversion_clock_in),
      .sclk(adcrm_link_if_i.sclk), .cs_n(adcrm_link_if_i.cs_n),
      .miso_oe(adcrm_link_if_i.miso_oe), .sync_n(adcrm_link_if_i.sync_n),
      .sample_ready_n(adcrm_link_if_i.sample_ready_n));

   always #12.5 pclk = ~pclk;

   // ***********************************************
   // helpers
   // ***********************************************
   task end_sim;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         fails++;
      end
   endtask

   function automatic logic [15:0] crc_m(input logic [23:0] v);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 23; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? `ADCRM_CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         fails++;
         end_sim();
      end
   endtask

   // one frame, then rdata fetched into q
   task link(input logic rd, input logic [1:0] sel, input logic [5:0] a,
         input logic [15:0] wd);
      int k;
      apb(1'b1, `ADCRM_OFS_ADDR, {26'h0, a});
      apb(1'b1, `ADCRM_OFS_WDATA, {16'h0, wd});
      apb(1'b1, `ADCRM_OFS_CTRL, {26'h0, sel, 2'b00, rd, 1'b1});
      k = 0;
      do begin
         apb(1'b0, `ADCRM_OFS_STATUS, 32'h0);
         k++;
      end while (q[1] !== 1'b1 && k < 2000);
      if (k >= 2000) begin
         fails++;
         end_sim();
      end
      apb(1'b1, `ADCRM_OFS_STATUS, 32'h2);
      apb(1'b0, `ADCRM_OFS_RDATA, 32'h0);
   endtask

   // one ready pulse seen, then past its end
   task wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (adcrm_link_if_i.sample_ready_n !== 1'b0 && k < 200);
      if (k >= 200) begin
         fails++;
         end_sim();
      end
      repeat (6) @(posedge pclk);
   endtask

   initial begin
      void'($urandom(32'h401c638e));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (40) @(posedge pclk);
      chk({24'h0, gain_o}, 32'h0);
      chk({16'h0, crc_o}, 32'h0);
      link(1'b1, 2'd0, 6'h3e, 16'h0);
      chk(q, 32'h0);
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 16'hffff : 16'($urandom);
         link(1'b0, 2'd0, 6'h30, d);
         gain_m = d[15:8];
         chk({24'h0, gain_o}, {24'h0, gain_m});
         chk({16'h0, crc_o}, {16'h0, crc_m({gain_m, 16'h0})});
         link(1'b1, 2'd0, 6'h30, 16'h0);
         chk(q, {16'h0, gain_m, 8'h00});
         link(1'b1, 2'd0, 6'h3e, 16'h0);
         chk(q, {16'h0, crc_m({gain_m, 16'h0})});
      end
      link(1'b0, 2'd0, 6'h3e, 16'($urandom));
      link(1'b0, 2'd0, 6'h3f, 16'($urandom));
      link(1'b1, 2'd0, 6'h3e, 16'h0);
      chk(q, {16'h0, crc_m({gain_m, 16'h0})});
      link(1'b1, 2'd0, 6'h3f, 16'h0);
      chk(q, 32'h0);
      apb(1'b1, `ADCRM_OFS_RDATA, 32'hffff);
      apb(1'b0, `ADCRM_OFS_RDATA, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      link(1'b0, 2'd1, 6'h30, {~gain_m, 8'h00});
      chk({24'h0, gain_o}, {24'h0, gain_m});
      wait_rdy();
      apb(1'b0, `ADCRM_OFS_STATUS, 32'h0);
      c0 = q[15:8];
      repeat (3) wait_rdy();
      apb(1'b0, `ADCRM_OFS_STATUS, 32'h0);
      chk({24'h0, q[15:8]}, {24'h0, c0 + 8'h03});
      apb(1'b1, `ADCRM_OFS_CTRL, 32'h4);
      repeat (100) @(posedge pclk);
      end_sim();
   end
endmodule
